// file: rtl/pirc_pkg.sv
// Constants, types and register map of the two-level interrupt controller.
// Assumes one 20 MHz clock, with the core instruction cycle derived from it as an enable.
package pirc_pkg;

  localparam int NUM_SRC = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int PC_W = 21;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_RESET_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_FLAG = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PRIO = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_PERIPH = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h6;

  // Field positions
  localparam int PRIO_EN_BIT = 7;
  localparam int HIGH_GIE_BIT = 7;
  localparam int LOW_GIE_BIT = 6;
  localparam int STAT_HIGH_ACTIVE_BIT = 7;
  localparam int STAT_LOW_ACTIVE_BIT = 6;
  localparam int STAT_BUSY_BIT = 5;
  localparam int STAT_LEVEL_BIT = 4;

  // Reset values
  localparam logic [DATA_W-1:0] RESET_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] FLAG_RST = 8'h00;
  localparam logic [DATA_W-1:0] ENABLE_RST = 8'h00;
  localparam logic [DATA_W-1:0] PRIO_RST = 8'hFF;
  localparam logic [DATA_W-1:0] PERIPH_RST = 8'hF0;

  // Vector addresses
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int CLKS_PER_INSTR = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLKS_PER_INSTR - 1);
  localparam int LATENCY_INSTR = 3;
  localparam logic [1:0] LAT_LAST = 2'(LATENCY_INSTR - 1);

  typedef enum logic {PIRC_IDLE, PIRC_WAIT} pirc_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pirc_bus_t;

  typedef struct packed {
    logic take;
    logic hi_level;
    logic [PC_W-1:0] ret_addr;
    logic [PC_W-1:0] vec_addr;
  } pirc_vec_t;

endpackage

// file: rtl/pirc_top.sv
// Two-level interrupt controller: flags, enables, priorities and vectoring to the core.
// Assumes bus and core inputs are synchronous to clock; events are one-cycle pulses.
module pirc_top
  import pirc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire pirc_bus_t bus,
  output logic [DATA_W-1:0] rdata,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [PC_W-1:0] core_pc,
  input wire logic return_from_handler_instr,
  output pirc_vec_t vec
);

  function automatic logic hit(input pirc_bus_t b, input logic [ADDR_W-1:0] off);
    hit = b.wr && (b.addr == off);
  endfunction

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic instr_en_reg;
  logic [DATA_W-1:0] reset_control_reg;
  logic [DATA_W-1:0] irq_control_reg;
  logic [DATA_W-1:0] irq_control_next;
  logic [DATA_W-1:0] flag_reg;
  logic [DATA_W-1:0] flag_next;
  logic [DATA_W-1:0] enable_reg;
  logic [DATA_W-1:0] prio_reg;
  logic [DATA_W-1:0] periph_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] status_word;
  pirc_state_t state_reg;
  pirc_state_t state_next;
  logic [1:0] lat_reg;
  logic [1:0] lat_next;
  logic level_reg;
  logic in_high_reg;
  logic in_low_reg;
  pirc_vec_t vec_reg;

  // Instruction cycle enable: one pulse every four clocks
  assign div_next = (div_reg == DIV_LAST) ? '0 : DIV_W'(div_reg + 1'b1);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= '0;
      instr_en_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      instr_en_reg <= (div_reg == DIV_LAST);
    end
  end

  // Mode and qualification
  wire priority_feature_enable = reset_control_reg[PRIO_EN_BIT];
  wire high_level_global_enable = irq_control_reg[HIGH_GIE_BIT];
  wire low_level_global_enable = irq_control_reg[LOW_GIE_BIT];
  wire global_irq_enable = irq_control_reg[HIGH_GIE_BIT];
  wire peripheral_irq_enable = irq_control_reg[LOW_GIE_BIT];

  wire [NUM_SRC-1:0] armed = flag_reg & enable_reg;
  // Priority bits play no part here
  wire [NUM_SRC-1:0] compat_q = armed & (~periph_reg | {NUM_SRC{peripheral_irq_enable}})
    & {NUM_SRC{global_irq_enable}};
  wire [NUM_SRC-1:0] high_q = armed & prio_reg & {NUM_SRC{high_level_global_enable}};
  // Clearing the high enable masks the low level too, so a high handler is never interrupted
  wire [NUM_SRC-1:0] low_q = armed & ~prio_reg
    & {NUM_SRC{low_level_global_enable & high_level_global_enable}};
  wire take_high = priority_feature_enable ? (|high_q) : (|compat_q);
  wire take_low = priority_feature_enable && !(|high_q) && (|low_q);
  wire accept = (state_reg == PIRC_IDLE) && instr_en_reg && (take_high || take_low);
  wire fire = (state_reg == PIRC_WAIT) && instr_en_reg && (lat_reg == LAT_LAST);

  // Sequencer: fixed latency from acceptance to vector, independent of instruction length
  always_comb begin
    state_next = state_reg;
    lat_next = lat_reg;
    case (state_reg)
      PIRC_IDLE: begin
        lat_next = '0;
        if (accept) begin
          state_next = PIRC_WAIT;
        end
      end
      PIRC_WAIT: begin
        if (fire) begin
          state_next = PIRC_IDLE;
          lat_next = '0;
        end else if (instr_en_reg) begin
          lat_next = 2'(lat_reg + 1'b1);
        end
      end
      default: begin
        state_next = PIRC_IDLE;
        lat_next = '0;
      end
    endcase
  end

  // Hardware set wins over a software clear in the same cycle
  assign flag_next = (hit(bus, OFF_FLAG) ? bus.wdata : flag_reg) | src_event;

  // Global enables: software write, then clear on accept, then set on return
  always_comb begin
    irq_control_next = hit(bus, OFF_IRQ_CTRL) ? bus.wdata : irq_control_reg;
    if (accept) begin
      if (take_high) begin
        irq_control_next[HIGH_GIE_BIT] = 1'b0;
      end else begin
        irq_control_next[LOW_GIE_BIT] = 1'b0;
      end
    end
    if (return_from_handler_instr) begin
      if (in_low_reg && !in_high_reg) begin
        irq_control_next[LOW_GIE_BIT] = 1'b1;
      end else begin
        irq_control_next[HIGH_GIE_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reset_control_reg <= RESET_CTRL_RST;
      irq_control_reg <= IRQ_CTRL_RST;
      flag_reg <= FLAG_RST;
      enable_reg <= ENABLE_RST;
      prio_reg <= PRIO_RST;
      periph_reg <= PERIPH_RST;
    end else begin
      if (hit(bus, OFF_RESET_CTRL)) begin
        reset_control_reg <= bus.wdata;
      end
      if (hit(bus, OFF_ENABLE)) begin
        enable_reg <= bus.wdata;
      end
      if (hit(bus, OFF_PRIO)) begin
        prio_reg <= bus.wdata;
      end
      if (hit(bus, OFF_PERIPH)) begin
        periph_reg <= bus.wdata;
      end
      irq_control_reg <= irq_control_next;
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= PIRC_IDLE;
      lat_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      lat_reg <= lat_next;
      if (accept) begin
        level_reg <= take_high;
      end
    end
  end

  // Active handler levels, so the return restores the right enable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_high_reg <= 1'b0;
      in_low_reg <= 1'b0;
    end else if (fire) begin
      if (level_reg) begin
        in_high_reg <= 1'b1;
      end else begin
        in_low_reg <= 1'b1;
      end
    end else if (return_from_handler_instr) begin
      if (in_high_reg) begin
        in_high_reg <= 1'b0;
      end else begin
        in_low_reg <= 1'b0;
      end
    end
  end

  // Vector to the core: one-cycle take with push data and target
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      vec_reg <= '0;
    end else begin
      vec_reg.take <= fire;
      if (fire) begin
        vec_reg.hi_level <= level_reg;
        vec_reg.ret_addr <= core_pc;
        vec_reg.vec_addr <= level_reg ? VEC_HIGH : VEC_LOW;
      end
    end
  end

  // Read path; unmapped offsets read zero
  assign status_word = {in_high_reg, in_low_reg, (state_reg == PIRC_WAIT), level_reg, 4'h0};

  assign read_mux =
    (bus.addr == OFF_RESET_CTRL) ? reset_control_reg :
    (bus.addr == OFF_IRQ_CTRL) ? irq_control_reg :
    (bus.addr == OFF_FLAG) ? flag_reg :
    (bus.addr == OFF_ENABLE) ? enable_reg :
    (bus.addr == OFF_PRIO) ? prio_reg :
    (bus.addr == OFF_PERIPH) ? periph_reg :
    (bus.addr == OFF_STATUS) ? status_word : 8'h00;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= bus.rd ? read_mux : 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign vec = vec_reg;

endmodule // pirc_top

// file: testbench/pirc_assertions.sv
// Port checker for the two-level interrupt controller.
// Assumes one clock domain and the active-low asynchronous reset.
module pirc_checker
  import pirc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire pirc_bus_t bus,
  input wire logic [DATA_W-1:0] rdata,
  input wire pirc_vec_t vec
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Shadow of the priority enable, kept from bus writes only
  logic mode_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) mode_reg <= 1'b0;
    else if (bus.wr && bus.addr == OFF_RESET_CTRL) mode_reg <= bus.wdata[PRIO_EN_BIT];
  end
  property p_map;
    vec.take |-> vec.vec_addr == (vec.hi_level ? VEC_HIGH : VEC_LOW);
  endproperty
  a_map: assert property (p_map) else $error("vector does not match level");
  property p_compat;
    vec.take && !mode_reg |-> vec.hi_level && vec.vec_addr == VEC_HIGH;
  endproperty
  a_compat: assert property (p_compat) else $error("compat vector wrong");
  property p_pulse;
    vec.take |=> !vec.take [*4];
  endproperty
  a_pulse: assert property (p_pulse) else $error("take not a lone pulse");
  property p_ret_hold;
    !vec.take |-> $stable(vec.ret_addr);
  endproperty
  a_ret_hold: assert property (p_ret_hold) else $error("return address moved");
  property p_vec_hold;
    !vec.take |-> $stable(vec.vec_addr) && $stable(vec.hi_level);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved without take");
  property p_en_rw;
    bus.wr && bus.addr == OFF_ENABLE ##1 bus.rd && bus.addr == OFF_ENABLE |=> rdata == $past(bus.wdata, 2);
  endproperty
  a_en_rw: assert property (p_en_rw) else $error("enable readback wrong");
  property p_prio_rw;
    bus.wr && bus.addr == OFF_PRIO ##1 bus.rd && bus.addr == OFF_PRIO |=> rdata == $past(bus.wdata, 2);
  endproperty
  a_prio_rw: assert property (p_prio_rw) else $error("priority readback wrong");
  property p_mode_rw;
    bus.rd && bus.addr == OFF_RESET_CTRL |=> rdata[PRIO_EN_BIT] == mode_reg;
  endproperty
  a_mode_rw: assert property (p_mode_rw) else $error("priority enable readback wrong");
endmodule // pirc_checker

bind pirc_top pirc_checker pirc_checker_i (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata), .vec(vec));

// file: testbench/pirc_core_model.sv
// Core model: pushes the return address per vector, pops it on return.
// Assumes vec is registered on clock.
module pirc_core_model
  import pirc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire pirc_vec_t vec,
  input wire logic ret_go,
  output logic [PC_W-1:0] core_pc,
  output logic return_from_handler_instr
);
  logic [PC_W-1:0] stack_q[$];
  always @(posedge clock or negedge rst_b) begin
    return_from_handler_instr <= 1'b0;
    if (!rst_b) begin
      core_pc <= 21'h000100;
      stack_q.delete();
    end else if (vec.take) begin
      stack_q.push_back(vec.ret_addr);
      core_pc <= vec.vec_addr;
    end else if (ret_go && stack_q.size() > 0) begin
      return_from_handler_instr <= 1'b1;
      core_pc <= stack_q.pop_back();
    end else begin
      core_pc <= core_pc + 21'h000001;
    end
  end
endmodule // pirc_core_model

// file: testbench/tb_priority_interrupt_controller.sv
// Self-checking bench for the two-level interrupt controller.
// Assumes the core model on the vector link and a 50 ns clock.
module tb_priority_interrupt_controller
  import pirc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  pirc_bus_t bus = '0;
  logic [NUM_SRC-1:0] src_event = '0;
  logic ret_go = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [PC_W-1:0] core_pc;
  logic ret_instr;
  pirc_vec_t vec;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [DATA_W-1:0] rst_tab [8] = '{RESET_CTRL_RST, IRQ_CTRL_RST, FLAG_RST, ENABLE_RST,
    PRIO_RST, PERIPH_RST, 8'h00, 8'h00};
  pirc_top pirc_top_i (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata), .src_event(src_event),
    .core_pc(core_pc), .return_from_handler_instr(ret_instr), .vec(vec));
  pirc_core_model pirc_core_model_i (.clock(clock), .rst_b(rst_b), .vec(vec), .ret_go(ret_go),
    .core_pc(core_pc), .return_from_handler_instr(ret_instr));
  initial begin
    forever #25 clock = ~clock;
  end
  // Tests need about 250 cycles; twelve times that means a hang
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic op(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    bus <= '{wr: w, rd: r, addr: a, wdata: d};
  endtask
  // Write followed by an idle cycle, so a standing strobe never rewrites
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    op(1'b1, 1'b0, a, d);
    op(1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, a, 8'h00);
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic evt(input logic [NUM_SRC-1:0] v);
    @(posedge clock);
    src_event <= v;
    @(posedge clock);
    src_event <= '0;
  endtask
  task automatic ret();
    @(posedge clock);
    ret_go <= 1'b1;
    @(posedge clock);
    ret_go <= 1'b0;
  endtask
  task automatic wtake(input logic t, input logic [PC_W-1:0] ea, input logic eh, input logic lat);
    int n;
    logic [PC_W-1:0] pc_seen;
    n = 0;
    pc_seen = core_pc;
    // The core address standing at the issuing edge is the one that must be pushed
    while (vec.take !== 1'b1 && n < 40) begin
      pc_seen = core_pc;
      @(posedge clock);
      #1;
      n++;
    end
    `CHK("take", t, vec.take)
    if (t) begin
      `CHK("vec_addr", ea, vec.vec_addr)
      `CHK("hi_level", eh, vec.hi_level)
      `CHK("ret_addr", pc_seen, vec.ret_addr)
      if (lat) `CHK("latency", 1'b1, n >= 12 && n <= 16)
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(4'(i), rst_tab[i]);
    evt(8'h02);
    rdc(OFF_FLAG, 8'h02);
    wr(OFF_FLAG, 8'h00);
    op(1'b1, 1'b0, OFF_ENABLE, 8'h11);
    rdc(OFF_ENABLE, 8'h11);
    op(1'b1, 1'b0, OFF_PRIO, 8'h00);
    rdc(OFF_PRIO, 8'h00);
    wr(OFF_IRQ_CTRL, 8'h80);
    evt(8'h01);
    wtake(1'b1, VEC_HIGH, 1'b1, 1'b1);
    rdc(OFF_STATUS, 8'h90);
    rdc(OFF_IRQ_CTRL, 8'h00);
    wr(OFF_FLAG, 8'h00);
    ret();
    rdc(OFF_IRQ_CTRL, 8'h80);
    evt(8'h10);
    wtake(1'b0, VEC_HIGH, 1'b1, 1'b0);
    wr(OFF_IRQ_CTRL, 8'hC0);
    wtake(1'b1, VEC_HIGH, 1'b1, 1'b0);
    wr(OFF_FLAG, 8'h00);
    ret();
    rdc(OFF_IRQ_CTRL, 8'hC0);
    op(1'b1, 1'b0, OFF_RESET_CTRL, 8'h80);
    rdc(OFF_RESET_CTRL, 8'h80);
    op(1'b1, 1'b0, OFF_PRIO, 8'h01);
    rdc(OFF_PRIO, 8'h01);
    wr(OFF_ENABLE, 8'h03);
    evt(8'h03);
    wtake(1'b1, VEC_HIGH, 1'b1, 1'b1);
    rdc(OFF_IRQ_CTRL, 8'h40);
    wr(OFF_FLAG, 8'h02);
    ret();
    wtake(1'b1, VEC_LOW, 1'b0, 1'b0);
    rdc(OFF_STATUS, 8'h40);
    rdc(OFF_IRQ_CTRL, 8'h80);
    evt(8'h01);
    wtake(1'b1, VEC_HIGH, 1'b1, 1'b1);
    rdc(OFF_STATUS, 8'hD0);
    rdc(OFF_IRQ_CTRL, 8'h00);
    wr(OFF_FLAG, 8'h00);
    ret();
    rdc(OFF_IRQ_CTRL, 8'h80);
    ret();
    rdc(OFF_IRQ_CTRL, 8'hC0);
    // Reset in mid-run must bring priority mode and priorities back
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rdc(OFF_RESET_CTRL, RESET_CTRL_RST);
    rdc(OFF_PRIO, PRIO_RST);
    rdc(OFF_IRQ_CTRL, IRQ_CTRL_RST);
    final_report();
  end
endmodule // tb_priority_interrupt_controller
